// ---- hdl/dmaar_channel.sv ----
// One DMA channel: address stepping, indirect addressing, count and reload.
// Assumes synchronous inputs on clk_sys and a data mover that drains the
// two-entry transfer buffer with valid/ready.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module dmaar_channel
	import dmaar_pkg::*;
#(
	parameter int IDX_W     = 4,
	parameter int BUF_DEPTH = 2
)(
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic [REG_AW-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [DATA_W-1:0]      reg_rdata,
	input  wire logic              trig_in,
	input  wire logic [IDX_W-1:0]  peripheral_short_index,
	output logic                   xfer_valid,
	input  wire logic              xfer_ready,
	output dmaar_xfer_s            xfer_data,
	output logic                   trig_ready
);

	localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
	localparam int CNT_BW = $clog2(BUF_DEPTH + 1);
	localparam logic [CNT_BW-1:0] BUF_FULL = CNT_BW'(BUF_DEPTH);
	localparam logic [PTR_W-1:0]  PTR_LAST = PTR_W'(BUF_DEPTH - 1);

	// ==========================================================================
	// Helpers
	function automatic logic [ADDR_W-1:0] step_addr(
		input dmaar_amode_e      mode,
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] step
	);
		case (mode)
			AM_INC:  step_addr = a + step;
			AM_DEC:  step_addr = a - step;
			default: step_addr = a;
		endcase
	endfunction

	function automatic logic [ADDR_W-1:0] eff_addr(
		input dmaar_amode_e      mode,
		input logic [ADDR_W-1:0] base,
		input logic [IDX_W-1:0]  idx
	);
		if (mode == AM_INDIR)
			eff_addr = base | ADDR_W'(idx);
		else
			eff_addr = base;
	endfunction

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == PTR_LAST) ? '0 : p + 1'b1;
	endfunction

	// ==========================================================================
	// State
	dmaar_ctrl_s       ctrl_ff;
	logic [ADDR_W-1:0] src_ff;
	logic [ADDR_W-1:0] dst_ff;
	logic [CNT_W-1:0]  cnt_ff;
	logic [ADDR_W-1:0] src_shd_ff;
	logic [ADDR_W-1:0] dst_shd_ff;
	logic [CNT_W-1:0]  cnt_shd_ff;
	logic              done_ff;
	logic              pend_ff;
	logic [DATA_W-1:0] rdata_ff;
	dmaar_xfer_s       buf_ff [BUF_DEPTH];
	logic [PTR_W-1:0]  wptr_ff;
	logic [PTR_W-1:0]  rptr_ff;
	logic [CNT_BW-1:0] fill_ff;

	// ==========================================================================
	// Decode
	logic              wr_ctrl;
	logic              wr_src;
	logic              wr_dst;
	logic              wr_cnt;
	dmaar_ctrl_s       wctrl;
	logic              repeat_mode;
	logic              cont_mode;
	logic [ADDR_W-1:0] step;
	logic              push;
	logic              pop;
	logic              last;
	logic              reenable;
	logic              reen_reload;
	logic              addr_reload;
	dmaar_xfer_s       push_data;

	assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
	assign wr_src  = reg_wr && (reg_addr == REG_SRC);
	assign wr_dst  = reg_wr && (reg_addr == REG_DST);
	assign wr_cnt  = reg_wr && (reg_addr == REG_CNT);
	assign wctrl   = dmaar_ctrl_s'(reg_wdata & CTRL_WMASK);

	// Low mode bit marks the repeating modes, high bit the continuous ones
	assign repeat_mode = ctrl_ff.transfer_repeat_select[0];
	assign cont_mode   = ctrl_ff.transfer_repeat_select[1];
	assign step        = ctrl_ff.byte_size ? STEP_BYTE : STEP_WORD;

	// Zero count never issues; software must program a start value first
	assign push = ctrl_ff.channel_on && pend_ff && (cnt_ff != CNT_ZERO) && (fill_ff != BUF_FULL);
	assign pop  = xfer_valid && xfer_ready;
	assign last = push && (cnt_ff == CNT_ONE);

	// Re-enable after a finished run reloads if the reload bit is written set; resuming a stopped run does not
	assign reenable    = wr_ctrl && wctrl.channel_on && !ctrl_ff.channel_on;
	assign reen_reload = reenable && done_ff && wctrl.reload;
	assign addr_reload = (last && repeat_mode) || reen_reload;

	// Index is the peripheral's, wraps by plain OR within the base region
	always_comb
	begin
		push_data.src       = eff_addr(ctrl_ff.source_address_step_mode, src_ff,
			peripheral_short_index);
		push_data.dst       = eff_addr(ctrl_ff.dest_address_step_mode, dst_ff,
			peripheral_short_index);
		push_data.byte_size = ctrl_ff.byte_size;
	end

	// ==========================================================================
	// Control register
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			ctrl_ff <= dmaar_ctrl_s'(CTRL_RESET);
		else if (wr_ctrl)
			ctrl_ff <= wctrl;
		else if (last && !repeat_mode)
			ctrl_ff.channel_on <= 1'b0;
	end

	// ==========================================================================
	// Shadows for reload
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			src_shd_ff <= ADDR_RESET;
			dst_shd_ff <= ADDR_RESET;
			cnt_shd_ff <= CNT_RESET;
		end
		else
		begin
			if (wr_src)
				src_shd_ff <= reg_wdata;
			if (wr_dst)
				dst_shd_ff <= reg_wdata;
			if (wr_cnt)
				cnt_shd_ff <= reg_wdata;
		end
	end

	// ==========================================================================
	// Address pointers; indirect mode leaves them untouched
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			src_ff <= ADDR_RESET;
		else if (wr_src)
			src_ff <= reg_wdata;
		else if (addr_reload)
			src_ff <= src_shd_ff;
		else if (push)
			src_ff <= step_addr(ctrl_ff.source_address_step_mode, src_ff, step);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			dst_ff <= ADDR_RESET;
		else if (wr_dst)
			dst_ff <= reg_wdata;
		else if (addr_reload)
			dst_ff <= dst_shd_ff;
		else if (push)
			dst_ff <= step_addr(ctrl_ff.dest_address_step_mode, dst_ff, step);
	end

	// ==========================================================================
	// Transaction count
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			cnt_ff <= CNT_RESET;
		else if (wr_cnt)
			cnt_ff <= reg_wdata;
		else if (reen_reload)
			cnt_ff <= cnt_shd_ff;
		else if (last)
			cnt_ff <= cnt_shd_ff;
		else if (push)
			cnt_ff <= cnt_ff - CNT_ONE;
	end

	// ==========================================================================
	// Completion and trigger; a set in the clearing cycle wins
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			done_ff <= 1'b0;
		else if (last && !repeat_mode)
			done_ff <= 1'b1;
		else if (reenable)
			done_ff <= 1'b0;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			pend_ff <= 1'b0;
		else if (trig_in)
			pend_ff <= 1'b1;
		else if (push && (!cont_mode || last))
			pend_ff <= 1'b0;
	end

	assign trig_ready = !pend_ff;

	// ==========================================================================
	// Two-entry transfer buffer
	always_ff @(posedge clk_sys)
	begin
		if (push)
			buf_ff[wptr_ff] <= push_data;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			fill_ff <= '0;
		end
		else
		begin
			if (push)
				wptr_ff <= ptr_inc(wptr_ff);
			if (pop)
				rptr_ff <= ptr_inc(rptr_ff);
			if (push && !pop)
				fill_ff <= fill_ff + 1'b1;
			else if (pop && !push)
				fill_ff <= fill_ff - 1'b1;
		end
	end

	assign xfer_valid = (fill_ff != '0);
	assign xfer_data  = buf_ff[rptr_ff];

	// ==========================================================================
	// Register read, data one cycle after the strobe
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			rdata_ff <= '0;
		else if (reg_rd)
		begin
			case (reg_addr)
				REG_CTRL: rdata_ff <= ctrl_ff;
				REG_SRC:  rdata_ff <= src_ff;
				REG_DST:  rdata_ff <= dst_ff;
				REG_CNT:  rdata_ff <= cnt_ff;
				REG_STAT: rdata_ff <= {{(DATA_W-CNT_BW-2){1'b0}}, fill_ff, pend_ff, done_ff};
				default:  rdata_ff <= '0;
			endcase
		end
		else
			rdata_ff <= '0;
	end

	assign reg_rdata = rdata_ff;

	// ==========================================================================
	// Checks
	a_count_zero_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
		last && !wr_cnt |=> cnt_ff == $past(cnt_shd_ff))
		else $error("count not reloaded at zero");

	a_oneshot_self_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		last && !repeat_mode && !wr_ctrl |=> !ctrl_ff.channel_on && done_ff)
		else $error("non-repeating channel stayed on");

	a_repeat_addr_back: assert property (@(posedge clk_sys) disable iff (!rst_n)
		last && repeat_mode && !wr_src && !wr_dst && !wr_ctrl
		|=> src_ff == $past(src_shd_ff) && dst_ff == $past(dst_shd_ff) && ctrl_ff.channel_on)
		else $error("repeat mode addresses not restored");

	a_src_step_size: assert property (@(posedge clk_sys) disable iff (!rst_n)
		push && !last && !wr_src && ctrl_ff.source_address_step_mode == AM_INC
		|=> src_ff == $past(src_ff) + ($past(ctrl_ff.byte_size) ? STEP_BYTE : STEP_WORD))
		else $error("source increment wrong step");

	a_dst_dec_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		push && !last && !wr_dst && ctrl_ff.dest_address_step_mode == AM_DEC
		|=> dst_ff == $past(dst_ff) - ($past(ctrl_ff.byte_size) ? STEP_BYTE : STEP_WORD))
		else $error("destination decrement wrong step");

	a_indir_base_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
		push && !last && !wr_src && ctrl_ff.source_address_step_mode == AM_INDIR
		|=> $stable(src_ff))
		else $error("indirect base register changed");

	a_indir_or_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
		push && fill_ff == '0 && ctrl_ff.dest_address_step_mode == AM_INDIR
		|=> xfer_valid && xfer_data.dst == ($past(dst_ff) | ADDR_W'($past(peripheral_short_index))))
		else $error("indirect address not base OR index");

	a_resume_no_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reenable && !done_ff && !push |=> cnt_ff == $past(cnt_ff) && src_ff == $past(src_ff))
		else $error("resume reloaded registers");

	a_reenable_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reen_reload |=> cnt_ff == $past(cnt_shd_ff) && dst_ff == $past(dst_shd_ff) && !done_ff)
		else $error("re-enable after completion did not reload");

	a_shadow_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_cnt ##1 !wr_cnt[*2] |-> cnt_shd_ff == $past(reg_wdata, 2))
		else $error("count shadow not captured");

	a_buffer_no_overfill: assert property (@(posedge clk_sys) disable iff (!rst_n)
		fill_ff == BUF_FULL && !pop |=> fill_ff == BUF_FULL && $stable(wptr_ff))
		else $error("buffer written while full");

	// A stalled receiver must see the same head word until it takes it
	a_head_holds_stall: assert property (@(posedge clk_sys) disable iff (!rst_n)
		xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_data))
		else $error("head entry changed while stalled");

	a_oneshot_single_push: assert property (@(posedge clk_sys) disable iff (!rst_n)
		push && !cont_mode && !trig_in |=> trig_ready && !push)
		else $error("one-shot trigger issued more than one transfer");

endmodule

`default_nettype wire

// ---- shared/dmaar_pkg.sv ----
// Shared constants and types for the DMA channel address and reload block.
// Assumes a single system clock domain and a plain software register port.
package dmaar_pkg;

	// ==========================================================================
	// Widths
	localparam int ADDR_W = 16;
	localparam int CNT_W  = 16;
	localparam int DATA_W = 16;
	localparam int REG_AW = 3;

	// ==========================================================================
	// Register indices on the software port
	localparam logic [REG_AW-1:0] REG_CTRL = 3'h0;
	localparam logic [REG_AW-1:0] REG_SRC  = 3'h1;
	localparam logic [REG_AW-1:0] REG_DST  = 3'h2;
	localparam logic [REG_AW-1:0] REG_CNT  = 3'h3;
	localparam logic [REG_AW-1:0] REG_STAT = 3'h4;

	// ==========================================================================
	// Reset values, write mask, address steps
	localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] CTRL_WMASK = 16'h02FF;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_RESET  = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_ZERO   = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_ONE    = 16'h0001;
	localparam logic [ADDR_W-1:0] STEP_BYTE  = 16'h0001;
	localparam logic [ADDR_W-1:0] STEP_WORD  = 16'h0002;

	// ==========================================================================
	// Modes
	typedef enum logic [1:0] {
		AM_FIXED = 2'b00,
		AM_INC   = 2'b01,
		AM_DEC   = 2'b10,
		AM_INDIR = 2'b11
	} dmaar_amode_e;

	typedef enum logic [1:0] {
		TM_ONESHOT     = 2'b00,
		TM_REP_ONESHOT = 2'b01,
		TM_CONT        = 2'b10,
		TM_REP_CONT    = 2'b11
	} dmaar_transfer_repeat_select_e;

	// ==========================================================================
	// Control register layout, bit 15 down to bit 0
	typedef struct packed {
		logic [5:0]    rsv_hi;
		logic          reload;
		logic          rsv_8;
		dmaar_amode_e  source_address_step_mode;
		dmaar_amode_e  dest_address_step_mode;
		dmaar_transfer_repeat_select_e transfer_repeat_select;
		logic          byte_size;
		logic          channel_on;
	} dmaar_ctrl_s;

	// One transfer handed to the data mover
	typedef struct packed {
		logic [ADDR_W-1:0] src;
		logic [ADDR_W-1:0] dst;
		logic              byte_size;
	} dmaar_xfer_s;

endpackage

// ---- test/dmaar_channel_bench.sv ----
// Self-checking bench: queue model of address stepping and reload vs. the channel.
// Assumes dmaar_mover as the far side and a 10 MHz system clock.
`timescale 1ns/1ns
`default_nettype none

module dmaar_channel_bench
	import dmaar_pkg::*;
;
	localparam int IDX_W = 4;
	logic              clk_sys, rst_n, reg_wr, reg_rd, trig_in, stall, idx_step, idx_up;
	logic              xfer_valid, xfer_ready, trig_ready, m_done;
	logic [REG_AW-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, m_src, m_dst, m_cnt, s_src, s_dst, s_cnt;
	logic [IDX_W-1:0]  idx;
	dmaar_xfer_s       xfer_data;
	dmaar_ctrl_s       m_ctrl;
	dmaar_xfer_s       exp_q[$];
	int                err_total, samples_checked, cyc;

	dmaar_channel #(.IDX_W(IDX_W), .BUF_DEPTH(2)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
		.peripheral_short_index(idx), .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
		.xfer_data(xfer_data), .trig_ready(trig_ready));
	dmaar_mover #(.IDX_W(IDX_W)) mover (
		.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall), .idx_step(idx_step),
		.idx_up(idx_up), .xfer_ready(xfer_ready), .peripheral_short_index(idx));

	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// ==========================================================================
	// Reporting
	task automatic end_sim();
		$display("Mismatches %0d, comparisons %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(logic ok, string msg);
		samples_checked++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			end_sim();
		end
	end

	// Every accepted entry must be the model's next one
	always @(posedge clk_sys)
	begin
		if (rst_n && xfer_valid === 1'b1 && xfer_ready)
		begin
			chk(exp_q.size() > 0 && xfer_data === exp_q[0], "transfer entry");
			if (exp_q.size() > 0)
				void'(exp_q.pop_front());
		end
	end

	// ==========================================================================
	// Register port and model
	task automatic wr(logic [REG_AW-1:0] a, logic [DATA_W-1:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(logic [REG_AW-1:0] a, logic [DATA_W-1:0] e,
		logic [DATA_W-1:0] m = 16'hFFFF);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk((reg_rdata & m) === (e & m), "register read");
	endtask

	task automatic setr(logic [REG_AW-1:0] a, logic [DATA_W-1:0] d);
		if (a == REG_SRC) {m_src, s_src} = {d, d};
		if (a == REG_DST) {m_dst, s_dst} = {d, d};
		if (a == REG_CNT) {m_cnt, s_cnt} = {d, d};
		wr(a, d);
	endtask

	task automatic wctrl(dmaar_ctrl_s v);
		dmaar_ctrl_s n;
		n = v & CTRL_WMASK;
		if (!m_ctrl.channel_on && n.channel_on && m_done && n.reload)
			{m_src, m_dst, m_cnt} = {s_src, s_dst, s_cnt};
		if (!m_ctrl.channel_on && n.channel_on)
			m_done = 1'b0;
		m_ctrl = n;
		wr(REG_CTRL, v);
	endtask

	function automatic logic [ADDR_W-1:0] stepa(dmaar_amode_e m, logic [ADDR_W-1:0] a,
		logic [ADDR_W-1:0] s);
		case (m)
			AM_INC:  return a + s;
			AM_DEC:  return a - s;
			default: return a;
		endcase
	endfunction

	task automatic mpush();
		dmaar_xfer_s      x;
		logic [ADDR_W-1:0] st;
		st = m_ctrl.byte_size ? STEP_BYTE : STEP_WORD;
		x.src = (m_ctrl.source_address_step_mode == AM_INDIR) ? (m_src | ADDR_W'(idx)) : m_src;
		x.dst = (m_ctrl.dest_address_step_mode == AM_INDIR) ? (m_dst | ADDR_W'(idx)) : m_dst;
		x.byte_size = m_ctrl.byte_size;
		exp_q.push_back(x);
		m_src = stepa(m_ctrl.source_address_step_mode, m_src, st);
		m_dst = stepa(m_ctrl.dest_address_step_mode, m_dst, st);
		m_cnt = m_cnt - 1'b1;
		if (m_cnt == CNT_ZERO)
		begin
			m_cnt = s_cnt;
			if (m_ctrl.transfer_repeat_select[0])
				{m_src, m_dst} = {s_src, s_dst};
			else
				{m_ctrl.channel_on, m_done} = 2'b01;
		end
	endtask

	task automatic chkregs();
		rd(REG_SRC, m_src);
		rd(REG_DST, m_dst);
		rd(REG_CNT, m_cnt);
		rd(REG_CTRL, m_ctrl);
		chk(exp_q.size() == 0, "entries missing");
	endtask

	// Index moves one cycle ahead of the trigger so the push sees it settled
	task automatic trig(logic s);
		int k;
		@(posedge clk_sys);
		idx_step <= 1'b1;
		idx_up <= 1'($urandom % 2);
		@(posedge clk_sys);
		idx_step <= 1'b0;
		trig_in <= 1'b1;
		stall <= s;
		@(posedge clk_sys);
		trig_in <= 1'b0;
		if (m_ctrl.channel_on && m_ctrl.transfer_repeat_select[1])
			repeat (m_cnt) mpush();
		else if (m_ctrl.channel_on)
			mpush();
		if (s)
		begin
			repeat (6) @(posedge clk_sys);
			rd(REG_STAT, 16'h0008, 16'h000C);
			stall <= 1'b0;
		end
		for (k = 0; k < 200; k++)
		begin
			@(posedge clk_sys);
			#1;
			if (trig_ready === 1'b1 && xfer_valid === 1'b0)
				break;
		end
		chk(k < 200, "transfers did not drain");
	endtask

	// ==========================================================================
	// Main sequence
	initial
	begin
		dmaar_ctrl_s c;
		{rst_n, reg_wr, reg_rd, trig_in, stall, idx_step, idx_up, m_done} = '0;
		{reg_addr, reg_wdata, m_src, m_dst, m_cnt, s_src, s_dst, s_cnt} = '0;
		{err_total, samples_checked, cyc} = '0;
		m_ctrl = CTRL_RESET;
		void'($urandom(84648));
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(REG_CTRL, CTRL_RESET);
		rd(REG_CNT, CNT_RESET);
		chk(xfer_valid === 1'b0 && trig_ready === 1'b1, "idle after reset");
		wr(3'h6, 16'hFFFF);
		rd(3'h7, 16'h0000);
		wctrl(16'hFDFE);
		rd(REG_CTRL, m_ctrl);
		// Every source/destination pairing once, each transfer mode four times
		for (int i = 0; i < 16; i++)
		begin
			c = '0;
			c.source_address_step_mode = dmaar_amode_e'(i[3:2]);
			c.dest_address_step_mode = dmaar_amode_e'(i[1:0]);
			c.transfer_repeat_select = dmaar_transfer_repeat_select_e'(i[3:2] ^ i[1:0]);
			c.byte_size = 1'($urandom % 2);
			c.reload = 1'($urandom % 2);
			c.channel_on = 1'b1;
			setr(REG_SRC, 16'($urandom) & 16'hFFF0);
			setr(REG_DST, 16'($urandom) & 16'hFFF0);
			setr(REG_CNT, 16'(2 + $urandom % 3));
			wctrl(c);
			repeat (c.transfer_repeat_select[1] ? 1 + c.transfer_repeat_select[0]
				: m_cnt + c.transfer_repeat_select[0]) trig(c.transfer_repeat_select[1]);
			if (!c.transfer_repeat_select[0])
			begin
				rd(REG_STAT, 16'h0001, 16'h0001);
				chkregs();
				wctrl(c);
			end
			c.channel_on = 1'b0;
			wctrl(c);
			chkregs();
		end
		// Stop in mid-operation, resume without reload
		c = '0;
		c.source_address_step_mode = AM_INC;
		c.dest_address_step_mode = AM_DEC;
		c.reload = 1'b1;
		c.channel_on = 1'b1;
		setr(REG_CNT, 16'h0003);
		wctrl(c);
		trig(1'b0);
		c.channel_on = 1'b0;
		wctrl(c);
		c.channel_on = 1'b1;
		wctrl(c);
		trig(1'b0);
		chkregs();
		end_sim();
	end
endmodule
`default_nettype wire

// ---- test/dmaar_mover.sv ----
// Data mover and indirect-index peripheral facing the DMA channel.
// Assumes the bench sets the seed and pulses idx_step between triggers.
`timescale 1ns/1ns
`default_nettype none

module dmaar_mover
	import dmaar_pkg::*;
#(
	parameter int IDX_W = 4
)(
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             stall,
	input  wire logic             idx_step,
	input  wire logic             idx_up,
	output logic                  xfer_ready,
	output logic [IDX_W-1:0]      peripheral_short_index
);
	// ==========================================================================
	// Acceptance: random gaps, held low while stalled
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			xfer_ready <= 1'b0;
		else
			xfer_ready <= !stall && ($urandom % 3 != 0);
	end

	// ==========================================================================
	// Index kept by the peripheral, wraps inside its own width
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			peripheral_short_index <= '0;
		else if (idx_step)
			peripheral_short_index <= idx_up ? peripheral_short_index + 1'b1
				: peripheral_short_index - 1'b1;
	end
endmodule
`default_nettype wire
